// File: inc/alert_regs_pkg.sv
// Purpose: Constants for the alert mask and result low-bit registers
// Assumes: Byte registers reached over the management bus register port
// Notes:   Functional notes follow
package alert_regs_pkg;

  localparam int unsigned ADDR_W = 8;
  localparam int unsigned DATA_W = 8;
  localparam int unsigned RES_W  = 10;

  // Register offsets
  localparam logic [7:0] FAN_ONE_MIN_HIGH_ADDR     = 8'h55;
  localparam logic [7:0] CONFIG_TWO_ADDR           = 8'h73;
  localparam logic [7:0] ALERT_MASK_ONE_ADDR       = 8'h74;
  localparam logic [7:0] ALERT_MASK_TWO_ADDR       = 8'h75;
  localparam logic [7:0] VOLTAGE_RESULT_LOW_ADDR   = 8'h76;

  // Reset values
  localparam logic [7:0] FAN_ONE_MIN_HIGH_RESET    = 8'h00;
  localparam logic [7:0] CONFIG_TWO_RESET          = 8'h00;
  localparam logic [7:0] ALERT_MASK_ONE_RESET      = 8'h00;
  localparam logic [7:0] ALERT_MASK_TWO_RESET      = 8'h00;
  localparam logic [7:0] VOLTAGE_RESULT_LOW_RESET  = 8'h00;
  localparam logic [7:0] UNMAPPED_READ_VALUE       = 8'h00;

  // Field positions
  localparam int unsigned CHANNEL_SEL_LSB          = 5;
  localparam int unsigned SINGLE_CHANNEL_MODE_BIT  = 6;
  localparam int unsigned CONFIG_TWO_SPARE_BIT     = 7;
  localparam int unsigned SECOND_MASK_ENABLE_BIT   = 7;
  localparam int unsigned OVERTEMP_MASK_BIT        = 1;
  localparam logic [7:0]  MASK_TWO_WRITABLE        = 8'hFD;
  localparam logic        OVERTEMP_MASK_VALUE      = 1'b0;

  // Channel codes shared by selection and conversion results
  typedef enum logic [2:0] {
    CH_2V5         = 3'h0,
    CH_CORE_SUPPLY = 3'h1,
    CH_OWN_SUPPLY  = 3'h2,
    CH_5V          = 3'h3,
    CH_12V         = 3'h4,
    CH_REMOTE_ONE  = 3'h5,
    CH_LOCAL       = 3'h6,
    CH_REMOTE_TWO  = 3'h7
  } channel_t;

  localparam int unsigned HIGH_BYTE_COUNT = 4;
  localparam logic [3:0]  ALL_HIGH_PENDING = 4'hF;

endpackage : alert_regs_pkg

// File: rtl/alert_mask_and_result_lsb_regs.sv
// Purpose: Alert masks, single-channel select and result low-bit registers
// Assumes: Register port driven by the management bus slave, one cycle each
// Notes:   High-byte result registers live outside; they see o_results_frozen
`timescale 1ns/1ps
module alert_mask_and_result_lsb_regs (
  input  wire logic                               i_sys_clk,
  input  wire logic                               i_rst_b,
  input  wire logic [alert_regs_pkg::ADDR_W-1:0]  i_addr,
  input  wire logic                               i_wr_en,
  input  wire logic [alert_regs_pkg::DATA_W-1:0]  i_wr_data,
  input  wire logic                               i_rd_en,
  output logic      [alert_regs_pkg::DATA_W-1:0]  o_rd_data,
  output logic                                    o_rd_valid,
  input  wire logic                               i_config_lock,
  output logic      [alert_regs_pkg::DATA_W-1:0]  o_config_two,
  output logic                                    o_single_channel_mode,
  output logic      [2:0]                         o_channel_select,
  input  wire logic                               i_single_channel_mode_valid,
  input  wire logic [2:0]                         i_single_channel_mode_channel,
  input  wire logic [alert_regs_pkg::RES_W-1:0]   i_single_channel_mode_value,
  input  wire logic [3:0]                         i_high_byte_read,
  output logic                                    o_results_frozen,
  input  wire logic [4:0]                         i_volt_out_of_limit,
  input  wire logic [2:0]                         i_temp_out_of_limit,
  input  wire logic                               i_thermal_limit_signal,
  input  wire logic [3:0]                         i_fan_fault,
  input  wire logic [1:0]                         i_diode_fault,
  output logic                                    o_alert
);
  import alert_regs_pkg::*;

  typedef enum logic [1:0] {
    RES_LIVE   = 2'b01,
    RES_FROZEN = 2'b10
  } freeze_state_t;

  function automatic logic [7:0] effective_mask_two(
    input logic [7:0] mask_one,
    input logic [7:0] mask_two
  );
    // Second mask is inert until the enable bit of the first is set
    effective_mask_two = mask_one[SECOND_MASK_ENABLE_BIT] ? mask_two : 8'h00;
  endfunction : effective_mask_two

  ////////////////////////////////////////////////////////////////////////////
  // Storage
  logic [7:0]    fan_one_min_high;
  logic [7:0]    config_two;
  logic [7:0]    alert_mask_one;
  logic [7:0]    alert_mask_two;
  logic [7:0]    voltage_result_low_bits;
  logic [3:0]    high_pending;
  freeze_state_t freeze_state;
  freeze_state_t next_freeze_state;
  logic [3:0]    next_high_pending;

  ////////////////////////////////////////////////////////////////////////////
  // Decode
  wire wr_fan_one  = i_wr_en && (i_addr == FAN_ONE_MIN_HIGH_ADDR);
  wire wr_config   = i_wr_en && (i_addr == CONFIG_TWO_ADDR)
                     && !i_config_lock;
  wire wr_mask_one = i_wr_en && (i_addr == ALERT_MASK_ONE_ADDR);
  wire wr_mask_two = i_wr_en && (i_addr == ALERT_MASK_TWO_ADDR);
  wire rd_low_bits = i_rd_en && (i_addr == VOLTAGE_RESULT_LOW_ADDR);

  logic [7:0] read_mux;
  always_comb begin
    case (i_addr)
      FAN_ONE_MIN_HIGH_ADDR:   read_mux = fan_one_min_high;
      CONFIG_TWO_ADDR:         read_mux = config_two;
      ALERT_MASK_ONE_ADDR:     read_mux = alert_mask_one;
      ALERT_MASK_TWO_ADDR:     read_mux = alert_mask_two;
      VOLTAGE_RESULT_LOW_ADDR: read_mux = voltage_result_low_bits;
      default:                 read_mux = UNMAPPED_READ_VALUE;
    endcase
  end

  // Read-only overtemp bit keeps its fixed value
  wire [7:0] next_mask_two = (i_wr_data & MASK_TWO_WRITABLE)
      | ({7'h00, OVERTEMP_MASK_VALUE} << OVERTEMP_MASK_BIT);

  ////////////////////////////////////////////////////////////////////////////
  // Alert gating; masks act only here, never on results
  wire [7:0] mask_two_eff = effective_mask_two(alert_mask_one,
                                               alert_mask_two);
  wire [6:0] group_one_raw = {i_temp_out_of_limit,
                              i_volt_out_of_limit[3:0]};
  wire [7:0] group_two_raw = {i_diode_fault, i_fan_fault,
                              i_thermal_limit_signal,
                              i_volt_out_of_limit[4]};
  wire [6:0] group_one_live = group_one_raw & ~alert_mask_one[6:0];
  wire [7:0] group_two_live = group_two_raw & ~mask_two_eff;
  wire       next_alert     = (|group_one_live) || (|group_two_live);

  ////////////////////////////////////////////////////////////////////////////
  // Freeze control; a new low-bits read re-arms and wins over high reads
  always_comb begin
    next_freeze_state = freeze_state;
    next_high_pending = high_pending & ~i_high_byte_read;
    case (freeze_state)
      RES_LIVE: begin
        if (rd_low_bits) begin
          next_freeze_state = RES_FROZEN;
          next_high_pending = ALL_HIGH_PENDING;
        end
      end
      RES_FROZEN: begin
        if (rd_low_bits) begin
          next_high_pending = ALL_HIGH_PENDING;
        end else if (next_high_pending == 4'h0) begin
          next_freeze_state = RES_LIVE;
        end
      end
      default: begin
        next_freeze_state = RES_LIVE;
        next_high_pending = 4'h0;
      end
    endcase
  end

  // Result capture; channels above 5 V belong to the second register
  wire       frozen      = (freeze_state == RES_FROZEN);
  wire       take_result = i_single_channel_mode_valid && !frozen &&
                           (i_single_channel_mode_channel <= CH_5V);
  wire [2:0] pair_index  = i_single_channel_mode_channel;
  logic [7:0] next_low_bits;
  always_comb begin
    next_low_bits = voltage_result_low_bits;
    if (take_result) begin
      next_low_bits[{pair_index[1:0], 1'b0} +: 2] = i_single_channel_mode_value[1:0];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Registers
  always_ff @(posedge i_sys_clk) begin
    if (!i_rst_b) begin
      fan_one_min_high <= FAN_ONE_MIN_HIGH_RESET;
      config_two       <= CONFIG_TWO_RESET;
      alert_mask_one   <= ALERT_MASK_ONE_RESET;
      alert_mask_two   <= ALERT_MASK_TWO_RESET;
    end else begin
      if (wr_fan_one)  fan_one_min_high <= i_wr_data;
      if (wr_config)   config_two       <= i_wr_data;
      if (wr_mask_one) alert_mask_one   <= i_wr_data;
      if (wr_mask_two) alert_mask_two   <= next_mask_two;
    end
  end

  always_ff @(posedge i_sys_clk) begin
    if (!i_rst_b) begin
      voltage_result_low_bits <= VOLTAGE_RESULT_LOW_RESET;
      freeze_state            <= RES_LIVE;
      high_pending            <= 4'h0;
    end else begin
      voltage_result_low_bits <= next_low_bits;
      freeze_state            <= next_freeze_state;
      high_pending            <= next_high_pending;
    end
  end

  always_ff @(posedge i_sys_clk) begin
    if (!i_rst_b) begin
      o_rd_data        <= UNMAPPED_READ_VALUE;
      o_rd_valid       <= 1'b0;
      o_alert          <= 1'b0;
      o_results_frozen <= 1'b0;
    end else begin
      o_rd_data        <= i_rd_en ? read_mux : UNMAPPED_READ_VALUE;
      o_rd_valid       <= i_rd_en;
      o_alert          <= next_alert;
      o_results_frozen <= (next_freeze_state == RES_FROZEN);
    end
  end

  // Mode and channel come straight from stored bits
  assign o_config_two          = config_two;
  assign o_single_channel_mode = config_two[SINGLE_CHANNEL_MODE_BIT];
  assign o_channel_select      = fan_one_min_high[CHANNEL_SEL_LSB +: 3];

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  property p_lock_blocks_config;
    @(posedge i_sys_clk) disable iff (!i_rst_b)
      (i_wr_en && i_addr == CONFIG_TWO_ADDR && i_config_lock)
      |=> $stable(config_two);
  endproperty
  a_lock_blocks_config: assert property (p_lock_blocks_config)
    else $error("Locked config register changed");

  property p_spare_bit_stored;
    @(posedge i_sys_clk) disable iff (!i_rst_b)
      (i_wr_en && i_addr == CONFIG_TWO_ADDR && !i_config_lock)
      |=> o_config_two[7] == $past(i_wr_data[7]);
  endproperty
  a_spare_bit_stored: assert property (p_spare_bit_stored)
    else $error("Spare config bit not stored");

  property p_channel_select;
    @(posedge i_sys_clk) disable iff (!i_rst_b)
      (i_wr_en && i_addr == FAN_ONE_MIN_HIGH_ADDR)
      |=> o_channel_select == $past(i_wr_data[7:5]);
  endproperty
  a_channel_select: assert property (p_channel_select)
    else $error("Channel select not from written bits");

  // Built from the pins, not from the gating nets it is meant to check
  property p_mask_one_blocks;
    @(posedge i_sys_clk) disable iff (!i_rst_b)
      ((i_volt_out_of_limit[3:0] & ~alert_mask_one[3:0]) == 4'h0 &&
       !i_volt_out_of_limit[4] && i_temp_out_of_limit == 3'h0 &&
       !i_thermal_limit_signal && i_fan_fault == 4'h0 &&
       i_diode_fault == 2'h0) |=> !o_alert;
  endproperty
  a_mask_one_blocks: assert property (p_mask_one_blocks)
    else $error("Alert raised with all faults masked");

  property p_volt_unmasked;
    @(posedge i_sys_clk) disable iff (!i_rst_b)
      (|(i_volt_out_of_limit[3:0] & ~alert_mask_one[3:0])) |=> o_alert;
  endproperty
  a_volt_unmasked: assert property (p_volt_unmasked)
    else $error("Unmasked voltage fault missed alert");

  // Overtemp mask is fixed clear, so this condition always alerts
  property p_thermal_always;
    @(posedge i_sys_clk) disable iff (!i_rst_b)
      i_thermal_limit_signal |=> o_alert;
  endproperty
  a_thermal_always: assert property (p_thermal_always)
    else $error("Thermal limit missed alert");

  property p_temp_unmasked;
    @(posedge i_sys_clk) disable iff (!i_rst_b)
      (|(i_temp_out_of_limit & ~alert_mask_one[6:4])) |=> o_alert;
  endproperty
  a_temp_unmasked: assert property (p_temp_unmasked)
    else $error("Unmasked temperature fault missed alert");

  property p_mask_two_inert;
    @(posedge i_sys_clk) disable iff (!i_rst_b)
      (!alert_mask_one[7] && (i_fan_fault != 4'h0)) |=> o_alert;
  endproperty
  a_mask_two_inert: assert property (p_mask_two_inert)
    else $error("Second mask acted while disabled");

  property p_twelve_masked;
    @(posedge i_sys_clk) disable iff (!i_rst_b)
      (i_volt_out_of_limit[4] && !alert_mask_two[0]) |=> o_alert;
  endproperty
  a_twelve_masked: assert property (p_twelve_masked)
    else $error("Unmasked 12 V fault missed alert");

  property p_overtemp_read_only;
    @(posedge i_sys_clk) disable iff (!i_rst_b)
      wr_mask_two |=> alert_mask_two[1] == OVERTEMP_MASK_VALUE;
  endproperty
  a_overtemp_read_only: assert property (p_overtemp_read_only)
    else $error("Overtemp mask bit was written");

  property p_fan_masked;
    @(posedge i_sys_clk) disable iff (!i_rst_b)
      (|(i_fan_fault & ~mask_two_eff[5:2])) |=> o_alert;
  endproperty
  a_fan_masked: assert property (p_fan_masked)
    else $error("Unmasked fan fault missed alert");

  property p_diode_masked;
    @(posedge i_sys_clk) disable iff (!i_rst_b)
      (|(i_diode_fault & ~mask_two_eff[7:6])) |=> o_alert;
  endproperty
  a_diode_masked: assert property (p_diode_masked)
    else $error("Unmasked diode fault missed alert");

  property p_low_bits_capture;
    @(posedge i_sys_clk) disable iff (!i_rst_b)
      (i_single_channel_mode_valid && !frozen && i_single_channel_mode_channel == CH_5V)
      |=> voltage_result_low_bits[7:6] == $past(i_single_channel_mode_value[1:0]);
  endproperty
  a_low_bits_capture: assert property (p_low_bits_capture)
    else $error("5 V low bits not captured");

  property p_low_bits_read_only;
    @(posedge i_sys_clk) disable iff (!i_rst_b)
      (i_wr_en && i_addr == VOLTAGE_RESULT_LOW_ADDR && !i_single_channel_mode_valid)
      |=> $stable(voltage_result_low_bits);
  endproperty
  a_low_bits_read_only: assert property (p_low_bits_read_only)
    else $error("Low-bits register accepted a write");

  property p_freeze_holds;
    @(posedge i_sys_clk) disable iff (!i_rst_b)
      rd_low_bits |=> o_results_frozen;
  endproperty
  a_freeze_holds: assert property (p_freeze_holds)
    else $error("Low-bits read did not freeze results");

  // High reads may all land at once, so only the frozen cycles are held
  property p_frozen_stable;
    @(posedge i_sys_clk) disable iff (!i_rst_b)
      o_results_frozen |=> $stable(voltage_result_low_bits);
  endproperty
  a_frozen_stable: assert property (p_frozen_stable)
    else $error("Frozen low bits changed");

endmodule : alert_mask_and_result_lsb_regs

// File: tb/alert_mask_and_result_lsb_regs_bench.sv
// Purpose: Self-checking bench for masks, select and result low bits
// Assumes: Inputs change at the falling edge only
// Notes:   Fault vector order volt, temp, thermal, fan, diode
`timescale 1ns/1ps
module alert_mask_and_result_lsb_regs_bench;
  import alert_regs_pkg::*;
  logic        clk;
  logic        rst_b;
  logic [7:0]  addr;
  logic        wr_en;
  logic [7:0]  wr_data;
  logic        rd_en;
  logic [7:0]  rd_data;
  logic        rd_valid;
  logic        lock;
  logic [7:0]  cfg2;
  logic        mode;
  logic [2:0]  chsel;
  logic        cv;
  logic [2:0]  cch;
  logic [9:0]  cval;
  logic [3:0]  hbr;
  logic        frozen;
  logic [14:0] flt;
  logic        alert;
  int          errors;
  int          tests_run;
  // Mask position per fault, {mask_two, mask_one}; thermal is never masked
  function automatic int mpos(input int f);
    case (f)
      4:       mpos = 8;
      5, 6, 7: mpos = f - 1;
      default: mpos = (f < 4) ? f : f + 1;
    endcase
  endfunction : mpos
  alert_mask_and_result_lsb_regs i_alert_mask_and_result_lsb_regs (
    .i_sys_clk(clk), .i_rst_b(rst_b), .i_addr(addr), .i_wr_en(wr_en),
    .i_wr_data(wr_data), .i_rd_en(rd_en), .o_rd_data(rd_data),
    .o_rd_valid(rd_valid), .i_config_lock(lock), .o_config_two(cfg2),
    .o_single_channel_mode(mode), .o_channel_select(chsel),
    .i_single_channel_mode_valid(cv), .i_single_channel_mode_channel(cch), .i_single_channel_mode_value(cval),
    .i_high_byte_read(hbr), .o_results_frozen(frozen),
    .i_volt_out_of_limit(flt[4:0]), .i_temp_out_of_limit(flt[7:5]),
    .i_thermal_limit_signal(flt[8]), .i_fan_fault(flt[12:9]),
    .i_diode_fault(flt[14:13]), .o_alert(alert));
  smbus_host_model i_smbus_host_model (
    .i_sys_clk(clk), .o_addr(addr), .o_wr_en(wr_en), .o_wr_data(wr_data),
    .o_rd_en(rd_en), .i_rd_data(rd_data), .i_rd_valid(rd_valid));
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  //////////////////////////////////////////////////////////////////////////
  task automatic report_and_stop();
    $display("comparisons %0d mismatches %0d", tests_run, errors);
    if (errors == 0 && tests_run > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : report_and_stop
  task automatic chk(input logic [7:0] got, input logic [7:0] exp,
                     input string what);
    tests_run++;
    if (got !== exp) begin
      errors++;
      $display("ERROR at %0t: %s got %h exp %h", $time, what, got, exp);
    end
  endtask : chk
  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    logic [7:0] d;
    logic       ok;
    i_smbus_host_model.read(a, d, ok);
    chk({7'h00, ok}, 8'h01, "read answer");
    chk(d, exp, "read data");
  endtask : rd
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    i_smbus_host_model.write(a, d);
  endtask : wr
  task automatic single_channel_mode(input logic [2:0] ch, input logic [1:0] low);
    @(negedge clk);
    cv   = 1'b1;
    cch  = ch;
    cval = {8'h5A, low};
    @(negedge clk);
    cv   = 1'b0;
    cval = ~cval;
  endtask : single_channel_mode
  // Reads all four high bytes, then waits a bounded time for release
  task automatic release_all();
    int k;
    for (k = 0; k < 4; k++) begin
      chk({7'h00, frozen}, 8'h01, "still frozen");
      @(negedge clk);
      hbr = 4'h1 << k;
      @(negedge clk);
      hbr = 4'h0;
    end
    for (k = 0; k < 4 && frozen !== 1'b0; k++) @(negedge clk);
    if (frozen !== 1'b0) begin
      errors++;
      $display("ERROR at %0t: freeze never released", $time);
      report_and_stop();
    end
  endtask : release_all
  //////////////////////////////////////////////////////////////////////////
  initial begin
    int          i;
    logic [15:0] m;
    rst_b = 1'b0;
    lock  = 1'b0;
    cv    = 1'b0;
    cch   = 3'h0;
    cval  = 10'h000;
    hbr   = 4'h0;
    flt   = 15'h0000;
    errors    = 0;
    tests_run = 0;
    repeat (4) @(negedge clk);
    rst_b = 1'b1;
    rd(ALERT_MASK_ONE_ADDR, ALERT_MASK_ONE_RESET);
    rd(ALERT_MASK_TWO_ADDR, ALERT_MASK_TWO_RESET);
    rd(VOLTAGE_RESULT_LOW_ADDR, VOLTAGE_RESULT_LOW_RESET);
    rd(8'h10, UNMAPPED_READ_VALUE);
    wr(ALERT_MASK_ONE_ADDR, 8'hA5);
    wr(ALERT_MASK_TWO_ADDR, 8'hFF);
    wr(VOLTAGE_RESULT_LOW_ADDR, 8'hFF);
    rd(ALERT_MASK_ONE_ADDR, 8'hA5);
    rd(ALERT_MASK_TWO_ADDR, 8'hFD);
    rd(VOLTAGE_RESULT_LOW_ADDR, 8'h00);
    release_all();
    $display("test registers done");
    wr(CONFIG_TWO_ADDR, 8'hC0);
    rd(CONFIG_TWO_ADDR, 8'hC0);
    chk({7'h00, mode}, 8'h01, "single channel mode");
    lock = 1'b1;
    wr(CONFIG_TWO_ADDR, 8'h00);
    chk(cfg2, 8'hC0, "locked config");
    lock = 1'b0;
    for (i = 0; i < 8; i++) begin
      wr(FAN_ONE_MIN_HIGH_ADDR, {i[2:0], 5'h1F});
      chk({5'h00, chsel}, i[7:0], "channel select");
    end
    $display("test config done");
    for (i = 0; i < 15; i++) begin
      wr(ALERT_MASK_ONE_ADDR, 8'h00);
      wr(ALERT_MASK_TWO_ADDR, 8'h00);
      flt = 15'h0001 << i;
      @(negedge clk);
      chk({7'h00, alert}, 8'h01, "unmasked alert");
      m = 16'h0001 << mpos(i);
      if (mpos(i) >= 8) m[7] = 1'b1;
      wr(ALERT_MASK_ONE_ADDR, m[7:0]);
      wr(ALERT_MASK_TWO_ADDR, m[15:8]);
      @(negedge clk);
      chk({7'h00, alert}, {7'h00, i == 8}, "masked alert");
      if (mpos(i) >= 8) begin
        wr(ALERT_MASK_ONE_ADDR, 8'h00);
        @(negedge clk);
        chk({7'h00, alert}, 8'h01, "second mask off");
      end
      flt = 15'h0000;
      @(negedge clk);
      chk({7'h00, alert}, 8'h00, "fault gone");
    end
    $display("test alert done");
    for (i = 0; i < 4; i++) single_channel_mode(i[2:0], i[1:0] ^ 2'b01);
    single_channel_mode(CH_12V, 2'b11);
    rd(VOLTAGE_RESULT_LOW_ADDR, 8'hB1);
    chk({7'h00, frozen}, 8'h01, "frozen after read");
    single_channel_mode(CH_2V5, 2'b11);
    release_all();
    rd(VOLTAGE_RESULT_LOW_ADDR, 8'hB1);
    release_all();
    single_channel_mode(CH_2V5, 2'b11);
    rd(VOLTAGE_RESULT_LOW_ADDR, 8'hB3);
    release_all();
    $display("test results done");
    report_and_stop();
  end
endmodule : alert_mask_and_result_lsb_regs_bench

// File: tb/smbus_host_model.sv
// Purpose: Host side of the register port, one byte per access
// Assumes: Strobes launched at the falling edge, sampled at the rising edge
// Notes:   Released write data is inverted so stale values never match
`timescale 1ns/1ps
module smbus_host_model (
  input  wire logic                              i_sys_clk,
  output logic      [alert_regs_pkg::ADDR_W-1:0] o_addr,
  output logic                                   o_wr_en,
  output logic      [alert_regs_pkg::DATA_W-1:0] o_wr_data,
  output logic                                   o_rd_en,
  input  wire logic [alert_regs_pkg::DATA_W-1:0] i_rd_data,
  input  wire logic                              i_rd_valid
);
  import alert_regs_pkg::*;
  initial begin
    o_addr    = 8'h00;
    o_wr_en   = 1'b0;
    o_wr_data = 8'h00;
    o_rd_en   = 1'b0;
  end
  //////////////////////////////////////////////////////////////////////////
  task automatic write(input logic [7:0] a, input logic [7:0] d);
    @(negedge i_sys_clk);
    o_addr    = a;
    o_wr_data = d;
    o_wr_en   = 1'b1;
    @(negedge i_sys_clk);
    o_wr_en   = 1'b0;
    o_wr_data = ~d;
  endtask : write
  // Answer is registered on the rising edge that samples the strobe, so no wait is needed
  task automatic read(input logic [7:0] a, output logic [7:0] d,
                      output logic ok);
    @(negedge i_sys_clk);
    o_addr  = a;
    o_rd_en = 1'b1;
    @(negedge i_sys_clk);
    o_rd_en = 1'b0;
    ok      = (i_rd_valid === 1'b1);
    d       = i_rd_data;
  endtask : read
endmodule : smbus_host_model
